// ### pkg/rbs_pkg.sv
// rbs_pkg: constants and types for the reset, boot and shutdown sequencer
package rbs_pkg;

  // ****************************************
  // clock and timing
  // ****************************************
  localparam int unsigned RBS_SYS_CLK_HZ = 100_000_000;
  localparam int unsigned RBS_RESET_DELAY_MS = 50;
  localparam int unsigned RBS_RESET_DELAY_CYC = (RBS_SYS_CLK_HZ / 1000) * RBS_RESET_DELAY_MS;
  // listening time for host traffic before falling back to the eeprom
  localparam int unsigned RBS_HOST_WINDOW_US = 100;
  localparam int unsigned RBS_HOST_WINDOW_CYC = (RBS_SYS_CLK_HZ / 1_000_000) * RBS_HOST_WINDOW_US;

  // ****************************************
  // sizes
  // ****************************************
  localparam int unsigned RBS_NUM_CORES = 8;
  localparam int unsigned RBS_EEPROM_IMAGE_BYTES = 32768;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic RBS_OSC_FAST_RST = 1'b0;
  localparam logic RBS_CLK_RUN_RST = 1'b0;
  localparam logic RBS_IO_FORCE_IN_RST = 1'b1;

  // ****************************************
  // system clock source choice
  // ****************************************
  typedef enum logic [1:0] {
    RBS_SRC_RC,
    RBS_SRC_XIN,
    RBS_SRC_PLL
  } rbs_clk_src_e;

endpackage

// ### rtl/rbs_delay_timer.sv
// rbs_delay_timer: one-shot down counter that pulses done COUNT cycles after start
`timescale 1ns/1ps
`default_nettype none
module rbs_delay_timer #(
  parameter int unsigned COUNT = 4,
  parameter int unsigned CNT_W = $clog2(COUNT + 1)
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic start,
  input wire logic abort,
  output logic busy,
  output logic done
);

  logic [CNT_W-1:0] cnt_q;

  // ****************************************
  // countdown
  // ****************************************
  // abort wins over a running count so a shutdown never leaves a stale done behind
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (abort) begin
        busy <= 1'b0;
      end else if (start) begin
        cnt_q <= CNT_W'(COUNT - 1);
        busy <= 1'b1;
      end else if (busy) begin
        if (cnt_q == '0) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          cnt_q <= cnt_q - CNT_W'(1);
        end
      end
    end
  end

endmodule
`default_nettype wire

// ### rtl/rbs_hub_arbiter.sv
// rbs_hub_arbiter: round-robin slot owner for the mutually exclusive hub resources
`timescale 1ns/1ps
`default_nettype none
module rbs_hub_arbiter
  import rbs_pkg::*;
#(
  parameter int unsigned N = RBS_NUM_CORES
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic slot_adv,
  input wire logic [N-1:0] core_active,
  input wire logic [N-1:0] req,
  output logic [N-1:0] grant
);

  localparam int unsigned PW = $clog2(N);
  logic [PW-1:0] ptr_q;

  // ****************************************
  // slot pointer
  // ****************************************
  // one slot per hub cycle, visiting every core in turn even when idle for fixed timing
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ptr_q <= '0;
    end else if (slot_adv) begin
      ptr_q <= (ptr_q == PW'(N - 1)) ? '0 : ptr_q + PW'(1);
    end
  end

  // ****************************************
  // grant, one owner at most
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < N; gi++) begin : g_grant
      // only the slot owner may win, so two grants can never coexist
      always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
          grant[gi] <= 1'b0;
        end else if (slot_adv) begin
          grant[gi] <= (ptr_q == PW'(gi)) && req[gi] && core_active[gi];
        end
      end
    end
  endgenerate

  property p_grant_single;
    @(posedge sys_clk) disable iff (!reset_n)
      $onehot0(grant) && ((grant & ~$past(core_active)) == '0 || $past(slot_adv) == 1'b0);
  endproperty
  a_grant_single: assert property (p_grant_single)
    else $error("hub granted to more than one core or to a stopped one");

endmodule
`default_nettype wire

// ### rtl/rbs_sequencer.sv
// rbs_sequencer: reset delay, boot decision, shutdown and clock selection for the core array
`timescale 1ns/1ps
`default_nettype none
module rbs_sequencer
  import rbs_pkg::*;
#(
  parameter int unsigned RESET_DELAY_CYCLES = RBS_RESET_DELAY_CYC,
  parameter int unsigned HOST_WINDOW_CYCLES = RBS_HOST_WINDOW_CYC,
  parameter int unsigned IMAGE_BYTES = RBS_EEPROM_IMAGE_BYTES,
  parameter int unsigned N = RBS_NUM_CORES
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic reset_in_n,
  input wire logic brownout_monitor_enable_n,
  input wire logic brownout_detect,
  input wire logic app_reboot_req,
  input wire logic [N-1:0] app_core_enable,
  input wire logic host_activity,
  input wire logic host_load_done,
  input wire logic host_suspend,
  input wire logic eeprom_probe_done,
  input wire logic eeprom_present,
  input wire logic eeprom_byte_valid,
  input wire logic [1:0] clk_cfg,
  input wire logic [N-1:0] hub_req,
  output logic [N-1:0] core_enable,
  output logic core0_loader_mode,
  output logic osc_fast,
  output logic sys_clk_run,
  output rbs_clk_src_e clk_src_sel,
  output logic hub_clk_en,
  output logic [N-1:0] hub_grant,
  output logic io_force_input,
  output logic boot_pin_mux,
  output logic host_talk_en,
  output logic eeprom_probe_req,
  output logic eeprom_copy_en,
  output logic boot_failed,
  output logic reset_pin_out,
  output logic reset_pin_oe
);

  localparam int unsigned CW = $clog2(IMAGE_BYTES);

  typedef enum logic [3:0] {
    ST_SHUTDOWN,
    ST_RST_DELAY,
    ST_HOST_WAIT,
    ST_HOST_LOAD,
    ST_EE_PROBE,
    ST_EE_COPY,
    ST_RUN,
    ST_SUSPEND,
    ST_PARKED
  } rbs_state_e;

  rbs_state_e state_q;
  rbs_state_e state_d;
  logic brownout_eff;
  logic sd_event;
  logic exit_ok;
  logic dly_start;
  logic dly_done;
  logic win_start;
  logic win_done;
  logic suspend_q;
  logic [CW-1:0] copy_cnt_q;
  logic copy_last;
  logic hub_phase_q;

  // ****************************************
  // shutdown causes
  // ****************************************
  // brown-out only counts while monitoring is enabled; reboot only from a running program
  assign brownout_eff = brownout_detect && !brownout_monitor_enable_n;
  assign sd_event = !reset_in_n || brownout_eff || (app_reboot_req && state_q == ST_RUN);
  assign exit_ok = reset_in_n && !brownout_eff;
  assign copy_last = eeprom_byte_valid && (copy_cnt_q == CW'(IMAGE_BYTES - 1));

  // timers start on entry to their waiting states
  assign dly_start = (state_d == ST_RST_DELAY) && (state_q != ST_RST_DELAY);
  assign win_start = (state_d == ST_HOST_WAIT) && (state_q != ST_HOST_WAIT);

  rbs_delay_timer #(
    .COUNT(RESET_DELAY_CYCLES)
  ) u_reset_delay (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .start(dly_start),
    .abort(sd_event),
    .busy(),
    .done(dly_done)
  );

  rbs_delay_timer #(
    .COUNT(HOST_WINDOW_CYCLES)
  ) u_host_window (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .start(win_start),
    .abort(sd_event),
    .busy(),
    .done(win_done)
  );

  // ****************************************
  // sequence state
  // ****************************************
  // any shutdown cause overrides every other step, including the parked state
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_SHUTDOWN: begin
        if (exit_ok) begin
          state_d = ST_RST_DELAY;
        end
      end
      ST_RST_DELAY: begin
        if (dly_done) begin
          state_d = ST_HOST_WAIT;
        end
      end
      ST_HOST_WAIT: begin
        if (host_activity) begin
          state_d = ST_HOST_LOAD;
        end else if (win_done) begin
          state_d = ST_EE_PROBE;
        end
      end
      ST_HOST_LOAD: begin
        if (host_load_done) begin
          state_d = (suspend_q || host_suspend) ? ST_SUSPEND : ST_RUN;
        end
      end
      ST_EE_PROBE: begin
        if (eeprom_probe_done) begin
          state_d = eeprom_present ? ST_EE_COPY : ST_PARKED;
        end
      end
      ST_EE_COPY: begin
        if (copy_last) begin
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        state_d = ST_RUN;
      end
      ST_SUSPEND: begin
        state_d = ST_SUSPEND;
      end
      ST_PARKED: begin
        state_d = ST_PARKED;
      end
    endcase
    if (sd_event) begin
      state_d = ST_SHUTDOWN;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ST_SHUTDOWN;
    end else begin
      state_q <= state_d;
    end
  end

  // ****************************************
  // boot bookkeeping
  // ****************************************
  // a suspend seen at any time during the host load sticks until the next boot
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      suspend_q <= 1'b0;
    end else if (state_q == ST_HOST_LOAD && host_suspend) begin
      suspend_q <= 1'b1;
    end else if (win_start) begin
      suspend_q <= 1'b0;
    end
  end

  // byte counter for the eeprom image; the copy ends only on the last byte
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      copy_cnt_q <= '0;
    end else if (state_q != ST_EE_COPY) begin
      copy_cnt_q <= '0;
    end else if (eeprom_byte_valid) begin
      copy_cnt_q <= copy_cnt_q + CW'(1);
    end
  end

  // ****************************************
  // core and oscillator control
  // ****************************************
  // outputs follow the next state so an input change shows one edge later
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      core_enable <= '0;
      core0_loader_mode <= 1'b0;
    end else begin
      unique case (state_d)
        ST_RUN: begin
          core_enable <= {app_core_enable[N-1:1], 1'b1};
          core0_loader_mode <= 1'b0;
        end
        ST_HOST_WAIT, ST_HOST_LOAD, ST_EE_PROBE, ST_EE_COPY, ST_SUSPEND: begin
          core_enable <= N'(1);
          core0_loader_mode <= 1'b1;
        end
        default: begin
          core_enable <= '0;
          core0_loader_mode <= 1'b0;
        end
      endcase
    end
  end

  // slow setting through shutdown, the reset delay and the parked state, fast from boot onward otherwise
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      osc_fast <= RBS_OSC_FAST_RST;
    end else begin
      osc_fast <= !(state_d inside {ST_SHUTDOWN, ST_RST_DELAY, ST_PARKED});
    end
  end

  // clock gate and pin float; the clock must keep running through the reset delay
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sys_clk_run <= RBS_CLK_RUN_RST;
      io_force_input <= RBS_IO_FORCE_IN_RST;
    end else begin
      sys_clk_run <= !(state_d inside {ST_SHUTDOWN, ST_PARKED});
      io_force_input <= state_d inside {ST_SHUTDOWN, ST_RST_DELAY, ST_PARKED};
    end
  end

  // ****************************************
  // boot pins and links
  // ****************************************
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      boot_pin_mux <= 1'b0;
      host_talk_en <= 1'b0;
      eeprom_probe_req <= 1'b0;
      eeprom_copy_en <= 1'b0;
      boot_failed <= 1'b0;
    end else begin
      boot_pin_mux <= !(state_d inside {ST_SHUTDOWN, ST_RUN, ST_PARKED});
      host_talk_en <= state_d inside {ST_HOST_WAIT, ST_HOST_LOAD};
      eeprom_probe_req <= (state_d == ST_EE_PROBE) && (state_q != ST_EE_PROBE);
      eeprom_copy_en <= state_d == ST_EE_COPY;
      boot_failed <= state_d == ST_PARKED;
    end
  end

  // weak pull-up drive on the reset pin only while the monitor is enabled
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      reset_pin_oe <= 1'b0;
      reset_pin_out <= 1'b0;
    end else begin
      reset_pin_oe <= !brownout_monitor_enable_n;
      reset_pin_out <= !brownout_monitor_enable_n;
    end
  end

  // ****************************************
  // clock source and hub rate
  // ****************************************
  // boot always runs on the rc oscillator; an unused code also falls back to it
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      clk_src_sel <= RBS_SRC_RC;
    end else if (state_d == ST_RUN && (clk_cfg == RBS_SRC_XIN || clk_cfg == RBS_SRC_PLL)) begin
      clk_src_sel <= rbs_clk_src_e'(clk_cfg);
    end else begin
      clk_src_sel <= RBS_SRC_RC;
    end
  end

  // divide by two; stopped clock also stops the hub slots
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      hub_phase_q <= 1'b0;
      hub_clk_en <= 1'b0;
    end else begin
      hub_phase_q <= sys_clk_run ? !hub_phase_q : 1'b0;
      hub_clk_en <= sys_clk_run && !hub_phase_q;
    end
  end

  // io pins and counter need no grant; only exclusive resources pass the arbiter
  rbs_hub_arbiter #(
    .N(N)
  ) u_hub (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .slot_adv(hub_clk_en),
    .core_active(core_enable),
    .req(hub_req),
    .grant(hub_grant)
  );

  // ****************************************
  // checks
  // ****************************************
  int unsigned rst_cyc_q;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_cyc_q <= 0;
    end else begin
      rst_cyc_q <= (state_q == ST_RST_DELAY) ? rst_cyc_q + 1 : 0;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  sequence s_parked;
    boot_failed && core_enable == '0 && io_force_input && !sys_clk_run;
  endsequence

  sequence s_restart;
    state_q == ST_SHUTDOWN ##1 state_q == ST_RST_DELAY;
  endsequence

  property p_reset_hold;
    !reset_in_n |=> core_enable == '0 && io_force_input;
  endproperty
  a_reset_hold: assert property (p_reset_hold)
    else $error("cores or pins active while reset input low");

  property p_delay_len;
    state_q == ST_RST_DELAY && state_d == ST_HOST_WAIT |-> rst_cyc_q == RESET_DELAY_CYCLES;
  endproperty
  a_delay_len: assert property (p_delay_len)
    else $error("reset delay length wrong");

  property p_osc_boot;
    state_q == ST_RST_DELAY ##1 state_q == ST_HOST_WAIT |-> osc_fast && $past(!osc_fast);
  endproperty
  a_osc_boot: assert property (p_osc_boot)
    else $error("oscillator not switched at end of reset delay");

  property p_core0_only;
    state_q == ST_HOST_WAIT |-> core_enable == N'(1) && core0_loader_mode;
  endproperty
  a_core0_only: assert property (p_core0_only)
    else $error("boot loader not alone on core 0");

  property p_host_first;
    state_q == ST_HOST_WAIT && host_activity && !sd_event |=> state_q == ST_HOST_LOAD && host_talk_en;
  endproperty
  a_host_first: assert property (p_host_first)
    else $error("host activity not served");

  property p_ee_probe;
    state_q == ST_HOST_WAIT && win_done && !host_activity && !sd_event |=> state_q == ST_EE_PROBE ##0 eeprom_probe_req;
  endproperty
  a_ee_probe: assert property (p_ee_probe)
    else $error("eeprom probe not started after host window");

  property p_copy_full;
    state_q == ST_EE_COPY && state_d == ST_RUN |-> copy_cnt_q == CW'(IMAGE_BYTES - 1) && eeprom_byte_valid;
  endproperty
  a_copy_full: assert property (p_copy_full)
    else $error("eeprom copy ended early");

  property p_park;
    state_q == ST_EE_PROBE && eeprom_probe_done && !eeprom_present && !sd_event |=> s_parked;
  endproperty
  a_park: assert property (p_park)
    else $error("failed boot did not park");

  property p_run_start;
    state_q == ST_HOST_LOAD && host_load_done && !host_suspend && !suspend_q && !sd_event
      |=> state_q == ST_RUN && !core0_loader_mode && core_enable[0];
  endproperty
  a_run_start: assert property (p_run_start)
    else $error("user program not started after load");

  property p_pins_free;
    state_q == ST_RUN |-> !boot_pin_mux;
  endproperty
  a_pins_free: assert property (p_pins_free)
    else $error("boot pins still claimed while running");

  property p_shutdown;
    sd_event |=> !sys_clk_run && io_force_input && state_q == ST_SHUTDOWN;
  endproperty
  a_shutdown: assert property (p_shutdown)
    else $error("shutdown not entered");

  property p_stay_down;
    state_q == ST_SHUTDOWN && !exit_ok |=> state_q == ST_SHUTDOWN;
  endproperty
  a_stay_down: assert property (p_stay_down)
    else $error("shutdown left while held");

  property p_reset_pin;
    ##1 reset_pin_oe == !$past(brownout_monitor_enable_n);
  endproperty
  a_reset_pin: assert property (p_reset_pin)
    else $error("reset pin drive mismatch");

  property p_boot_src;
    state_q != ST_RUN |-> clk_src_sel == RBS_SRC_RC;
  endproperty
  a_boot_src: assert property (p_boot_src)
    else $error("non rc clock source outside run");

  property p_hub_half;
    hub_clk_en |=> !hub_clk_en;
  endproperty
  a_hub_half: assert property (p_hub_half)
    else $error("hub enable faster than half rate");

  property p_reboot;
    state_q == ST_RUN && app_reboot_req && exit_ok ##1 exit_ok |-> s_restart;
  endproperty
  a_reboot: assert property (p_reboot)
    else $error("reboot did not restart the reset delay");

endmodule
`default_nettype wire

// ### tb/rbs_boot_partner.sv
// rbs_boot_partner: host serial link and optional eeprom seen from the sequencer
`timescale 1ns/1ps
`default_nettype none
module rbs_boot_partner (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic host_present,
  input wire logic suspend_cmd,
  input wire logic eeprom_fitted,
  input wire logic host_talk_en,
  input wire logic eeprom_probe_req,
  input wire logic eeprom_copy_en,
  output logic host_activity,
  output logic host_load_done,
  output logic host_suspend,
  output logic eeprom_probe_done,
  output logic eeprom_present,
  output logic eeprom_byte_valid
);
  // ********
  // host session and eeprom answers
  // ********
  logic [3:0] talk_q;
  logic [2:0] probe_q;
  logic toggle_q;
  // session runs on once started, so a dropped talk enable cannot hide the end
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      talk_q <= 4'h0;
    end else if (!host_present || (!host_talk_en && talk_q == 4'hf)) begin
      talk_q <= 4'h0;
    end else if ((talk_q != 4'h0 || host_talk_en) && talk_q != 4'hf) begin
      talk_q <= talk_q + 4'h1;
    end
  end
  assign host_activity = talk_q >= 4'h1 && talk_q <= 4'h3;
  assign host_suspend = suspend_cmd && talk_q == 4'h5;
  assign host_load_done = talk_q == 4'h7;
  // probe answer comes a few cycles late, bytes come every other cycle
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      probe_q <= 3'h0;
      toggle_q <= 1'b0;
    end else begin
      toggle_q <= !toggle_q;
      if (eeprom_probe_req) begin
        probe_q <= 3'h1;
      end else if (probe_q == 3'h4) begin
        probe_q <= 3'h0;
      end else if (probe_q != 3'h0) begin
        probe_q <= probe_q + 3'h1;
      end
    end
  end
  assign eeprom_probe_done = probe_q == 3'h4;
  // outside the answer cycle the presence line carries a changing pattern
  assign eeprom_present = eeprom_probe_done ? eeprom_fitted : toggle_q;
  assign eeprom_byte_valid = eeprom_copy_en && toggle_q;
endmodule
`default_nettype wire

// ### tb/reset_boot_shutdown_sequencer_tb_top.sv
// reset_boot_shutdown_sequencer_tb_top: self-checking bench for the sequencer
`timescale 1ns/1ps
`default_nettype none
module reset_boot_shutdown_sequencer_tb_top;
  import rbs_pkg::*;
  // ********
  // signals, dut and partner
  // ********
  localparam int RD = 20;
  logic sys_clk = 1'b0;
  logic reset_n, reset_in_n, brownout_monitor_enable_n, brownout_detect, app_reboot_req;
  logic [7:0] app_core_enable, hub_req, core_enable, hub_grant;
  logic [1:0] clk_cfg, cfg_prev;
  logic host_present, suspend_cmd, eeprom_fitted, hub_prev;
  logic host_activity, host_load_done, host_suspend, eeprom_probe_done, eeprom_present, eeprom_byte_valid;
  logic core0_loader_mode, osc_fast, sys_clk_run, hub_clk_en, io_force_input, boot_pin_mux;
  logic host_talk_en, eeprom_probe_req, eeprom_copy_en, boot_failed, reset_pin_out, reset_pin_oe;
  rbs_clk_src_e clk_src_sel;
  int fail_count = 0;
  int check_count = 0;
  int seed = 20;
  int plan_q[$] = '{0, 6, 4, 1};
  // slow counts shortened so a full boot takes tens of cycles
  rbs_sequencer #(.RESET_DELAY_CYCLES(RD), .HOST_WINDOW_CYCLES(8), .IMAGE_BYTES(16)) i_dut (
    .sys_clk, .reset_n, .reset_in_n, .brownout_monitor_enable_n, .brownout_detect, .app_reboot_req,
    .app_core_enable, .host_activity, .host_load_done, .host_suspend, .eeprom_probe_done, .eeprom_present,
    .eeprom_byte_valid, .clk_cfg, .hub_req, .core_enable, .core0_loader_mode, .osc_fast, .sys_clk_run,
    .clk_src_sel, .hub_clk_en, .hub_grant, .io_force_input, .boot_pin_mux, .host_talk_en, .eeprom_probe_req,
    .eeprom_copy_en, .boot_failed, .reset_pin_out, .reset_pin_oe);
  rbs_boot_partner i_partner (.sys_clk, .reset_n, .host_present, .suspend_cmd, .eeprom_fitted, .host_talk_en,
    .eeprom_probe_req, .eeprom_copy_en, .host_activity, .host_load_done, .host_suspend, .eeprom_probe_done,
    .eeprom_present, .eeprom_byte_valid);
  // free-running system clock
  always #5 sys_clk = ~sys_clk;
  // ********
  // tasks and main sequence
  // ********
  task automatic tally_and_finish();
    if (fail_count == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: %s", $time, what);
    end
  endtask
  // counts edges until the fast oscillator shows up, then checks the boot start
  task automatic measure();
    int n;
    n = 0;
    while (osc_fast !== 1'b1 && n < 100) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    chk(8'(n), 8'(RD + 2), "reset delay length");
    if (n >= 100) tally_and_finish();
    chk(core_enable, 8'h01, "only core 0 boots");
    chk(core0_loader_mode, 1'b1, "core 0 not in loader");
    chk(boot_pin_mux, 1'b1, "boot pins not claimed");
  endtask
  // reference outcome from the partner setup: bit2 host, bit1 suspend, bit0 eeprom
  task automatic settle(input int code);
    int n;
    bit run, park;
    run = (code[2] && !code[1]) || (!code[2] && code[0]);
    park = !code[2] && !code[0];
    n = 0;
    while (n < 600 && boot_failed !== 1'b1 && boot_pin_mux !== 1'b0 && !(code[1] && host_load_done === 1'b1)) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    if (n >= 600) begin
      fail_count++;
      $display("Error at %0t: boot never settled", $time);
      tally_and_finish();
    end
    repeat (2) @(posedge sys_clk);
    #1;
    chk(boot_failed, park, "park flag");
    chk(sys_clk_run, !park, "clock gate after boot");
    chk(core_enable[0], !park, "core 0 state");
    chk(core0_loader_mode, !run && !park, "core 0 program");
    if (run || park) chk(io_force_input, park, "pin direction after boot");
    if (run) chk(boot_pin_mux, 1'b0, "boot pins kept");
  endtask
  task automatic boot(input int code);
    @(posedge sys_clk);
    reset_in_n <= 1'b0;
    host_present <= code[2];
    suspend_cmd <= code[1];
    eeprom_fitted <= code[0];
    repeat (3) @(posedge sys_clk);
    #1;
    chk(core_enable, 8'h00, "cores on in reset");
    chk(io_force_input, 1'b1, "pins driven in reset");
    chk(sys_clk_run, 1'b0, "clock runs in shutdown");
    chk(osc_fast, 1'b0, "fast oscillator in reset");
    @(posedge sys_clk);
    reset_in_n <= 1'b1;
    measure();
    settle(code);
  endtask
  initial begin
    {reset_n, reset_in_n, brownout_detect, app_reboot_req, host_present, suspend_cmd, eeprom_fitted} = '0;
    {brownout_monitor_enable_n, app_core_enable, hub_req, clk_cfg} = {1'b1, 18'h0};
    repeat (12) @(posedge sys_clk);
    chk(clk_src_sel, RBS_SRC_RC, "clock source in reset");
    reset_n <= 1'b1;
    while (plan_q.size() > 0) boot(plan_q.pop_front());
    // random run-time traffic; clock source follows the value sampled at each edge
    #1;
    hub_prev = hub_clk_en;
    repeat (40) begin
      @(posedge sys_clk);
      cfg_prev = clk_cfg;
      clk_cfg <= 2'($random(seed));
      app_core_enable <= 8'($random(seed));
      hub_req <= 8'($random(seed));
      #1;
      chk(clk_src_sel, (cfg_prev == 2'h3) ? 8'h0 : 8'(cfg_prev), "clock source");
      chk(hub_clk_en, !hub_prev, "hub rate");
      chk(8'($onehot0(hub_grant)), 8'h01, "grant not exclusive");
      chk(core_enable[0], 1'b1, "core 0 dropped");
      hub_prev = hub_clk_en;
    end
    // brown-out ignored while monitoring is off, then honoured once it is on
    @(posedge sys_clk);
    brownout_detect <= 1'b1;
    repeat (4) @(posedge sys_clk);
    #1;
    chk(sys_clk_run, 1'b1, "disabled brown-out acted");
    chk(reset_pin_oe, 1'b0, "reset pin driven");
    @(posedge sys_clk);
    brownout_monitor_enable_n <= 1'b0;
    repeat (RD + 5) @(posedge sys_clk);
    #1;
    chk(reset_pin_oe, 1'b1, "monitor not driving");
    chk(reset_pin_out, 1'b1, "monitor level not high");
    chk(io_force_input, 1'b1, "brown-out left pins driven");
    chk(osc_fast, 1'b0, "left shutdown under brown-out");
    @(posedge sys_clk);
    brownout_detect <= 1'b0;
    measure();
    settle(1);
    // application reboot restarts the whole sequence
    @(posedge sys_clk);
    app_reboot_req <= 1'b1;
    @(posedge sys_clk);
    app_reboot_req <= 1'b0;
    #1;
    chk(sys_clk_run, 1'b0, "reboot ignored");
    measure();
    settle(1);
    tally_and_finish();
  end
endmodule
`default_nettype wire
